// ==== design/temp_alarm_interrupt.sv ====
/*
 * Temperature alarm interrupt logic with an AXI4-Lite register slave.
 * Assumes a conversion strobe and 9-bit half-degree result from the
 * converter on the same clock.
 */
// Overview of operation
// - Normal and extended options, three modes each.
// - Normal repetitive: above high latches interrupt.
// - Re-assert after read while above release point.
// - Normal one-time: single latch, rearm below release.
// - Normal comparator: follows high limit, no low/crit.
// - Extended latches clear by status or ext reads.
// - Extended repetitive low until above low+hyst.
// - Extended repetitive high until below high-hyst.
// - Extended repetitive crit until below crit-hyst.
// - Extended one-time low rearms above low+hyst.
// - Extended one-time high rearms below high-hyst.
// - Extended one-time crit rearms below crit-hyst.
// - Extended comparator low releases above low+hyst.
// - Extended comparator high releases below high-hyst.
// - Extended comparator crit releases below crit-hyst.
// - Critical alert status and enable in ext register.
// - Status read returns contents and clears.
// - Cleared status deasserts interrupt line.
// - Hold bit clears line and halts monitoring.
// - Per-flag mask and global line enable.
// - Flag drives line only when mask low.
// - Limits are 8-bit two's complement degrees.
// - Hysteresis is 3-bit unsigned degrees.
`timescale 1ns/1ps
module temp_alarm_interrupt
    import temp_alarm_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        conv_done,
    input  wire logic [8:0]  conv_temp,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             int_n,
    output logic             critical_alert_n,
    output logic             monitor_halt
);

    state_t s_reg;
    state_t s_next;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic signed [9:0] ext8(input logic signed [7:0] v);
        ext8 = {{2{v[7]}}, v};
    endfunction

    function automatic logic signed [9:0] hyst10(input logic [2:0] h);
        hyst10 = {7'h00, h};
    endfunction

    logic signed [9:0] t_deg;
    logic              hot;
    logic              cold;
    logic              crit_hot;
    logic              hot_clear;
    logic              cold_clear;
    logic              crit_clear;
    logic              hold;
    logic              do_write;
    logic              do_read;

    // Whole-degree temperature, floor of the half-degree result.
    assign t_deg      = 10'(signed'(conv_temp) >>> 1);
    assign hot        = t_deg >  ext8(s_reg.lim.high);
    assign cold       = t_deg <= ext8(s_reg.lim.low);
    assign crit_hot   = t_deg >  ext8(s_reg.lim.crit);
    // Normal one-time and repetitive modes release at the high limit less hysteresis.
    assign hot_clear  = t_deg <= ext8(s_reg.lim.high) - hyst10(s_reg.lim.hyst);
    // Release above low plus hysteresis in every extended mode.
    assign cold_clear = t_deg >  ext8(s_reg.lim.low) + hyst10(s_reg.lim.hyst);
    assign crit_clear = t_deg <= ext8(s_reg.lim.crit) - hyst10(s_reg.lim.hyst);
    assign hold       = s_reg.config_bits[CFG_INT_HOLD];
    assign do_write   = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
    assign do_read    = s_axi_arvalid && !s_reg.rvalid;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        // Alarm evaluation, halted by the hold bit.
        if (conv_done && !hold)
        begin
            s_next.temp = signed'(conv_temp);
            if (!s_reg.extended)
            begin
                case (s_reg.mode)
                    MODE_REPETITIVE:
                    begin
                        // Above release point sets again each time.
                        if (hot || (!hot_clear && s_reg.armed.high == 1'b0))
                            s_next.stat.high = 1'b1;
                        if (hot)
                            s_next.armed.high = 1'b0;
                        else if (hot_clear)
                            s_next.armed.high = 1'b1;
                    end
                    MODE_COMPARATOR:
                    begin
                        // Level follows the high limit only.
                        s_next.stat.high = hot;
                        s_next.stat.low  = 1'b0;
                    end
                    default:
                    begin
                        // One latch per excursion.
                        if (hot && s_reg.armed.high)
                        begin
                            s_next.stat.high  = 1'b1;
                            s_next.armed.high = 1'b0;
                        end
                        else if (hot_clear)
                            s_next.armed.high = 1'b1;
                    end
                endcase
            end
            else
            begin
                case (s_reg.mode)
                    MODE_REPETITIVE:
                    begin
                        // Recur until the hysteresis band is left.
                        if (cold)
                            s_next.armed.low = 1'b0;
                        else if (cold_clear)
                            s_next.armed.low = 1'b1;
                        if (hot)
                            s_next.armed.high = 1'b0;
                        else if (hot_clear)
                            s_next.armed.high = 1'b1;
                        if (crit_hot)
                            s_next.armed.crit = 1'b0;
                        else if (crit_clear)
                            s_next.armed.crit = 1'b1;
                        if (cold || (!cold_clear && !s_reg.armed.low))
                            s_next.stat.low = 1'b1;
                        if (hot || (!hot_clear && !s_reg.armed.high))
                            s_next.stat.high = 1'b1;
                        if (crit_hot || (!crit_clear && !s_reg.armed.crit))
                            s_next.stat.crit = 1'b1;
                    end
                    MODE_COMPARATOR:
                    begin
                        // Levels with hysteresis, no read needed.
                        if (cold)
                            s_next.stat.low = 1'b1;
                        else if (cold_clear)
                            s_next.stat.low = 1'b0;
                        if (hot)
                            s_next.stat.high = 1'b1;
                        else if (hot_clear)
                            s_next.stat.high = 1'b0;
                        if (crit_hot)
                            s_next.stat.crit = 1'b1;
                        else if (crit_clear)
                            s_next.stat.crit = 1'b0;
                    end
                    default:
                    begin
                        // One event per excursion on each side.
                        if (cold && s_reg.armed.low)
                        begin
                            s_next.stat.low  = 1'b1;
                            s_next.armed.low = 1'b0;
                        end
                        else if (cold_clear)
                            s_next.armed.low = 1'b1;
                        if (hot && s_reg.armed.high)
                        begin
                            s_next.stat.high  = 1'b1;
                            s_next.armed.high = 1'b0;
                        end
                        else if (hot_clear)
                            s_next.armed.high = 1'b1;
                        if (crit_hot && s_reg.armed.crit)
                        begin
                            s_next.stat.crit  = 1'b1;
                            s_next.armed.crit = 1'b0;
                        end
                        else if (crit_clear)
                            s_next.armed.crit = 1'b1;
                    end
                endcase
            end
        end

        // Write channel.
        if (s_axi_awvalid && !s_reg.aw_full)
        begin
            s_next.aw_full = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_full)
        begin
            s_next.w_full = 1'b1;
            s_next.w_data = s_axi_wdata;
        end
        if (do_write)
        begin
            s_next.aw_full = 1'b0;
            s_next.w_full  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            if (s_axi_wstrb[0])
            begin
                case (s_reg.aw_addr)
                    ADDR_CONFIG: s_next.config_bits = s_reg.w_data[7:0];
                    ADDR_MODE:
                    begin
                        // Option, mode and masks from software.
                        s_next.mode     = alarm_mode_t'(s_reg.w_data[1:0]);
                        s_next.extended = s_reg.w_data[MODE_EXTENDED];
                        s_next.int_mask = s_reg.w_data[5:4];
                    end
                    ADDR_LIMITS:
                    begin
                        // Limits are signed bytes, hysteresis 3 bits.
                        s_next.lim.high = s_reg.w_data[7:0];
                        s_next.lim.low  = s_reg.w_data[15:8];
                        s_next.lim.crit = s_reg.w_data[23:16];
                        s_next.lim.hyst = s_reg.w_data[26:24];
                    end
                    ADDR_EXT1: s_next.crit_en = s_reg.w_data[EXT1_CRIT_EN];
                    default:   s_next.bresp   = RESP_SLVERR;
                endcase
            end
        end
        if (s_reg.bvalid && s_axi_bready)
            s_next.bvalid = 1'b0;

        // Read channel, clear-on-read for status; a same-cycle conversion wins.
        if (do_read)
        begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            s_next.rdata  = 32'h0;
            case (s_axi_araddr)
                ADDR_CONFIG: s_next.rdata[7:0] = s_reg.config_bits;
                ADDR_MODE:
                    s_next.rdata[7:0] = {2'h0, s_reg.int_mask, 1'b0,
                                         s_reg.extended, s_reg.mode};
                ADDR_LIMITS:
                    s_next.rdata = {5'h00, s_reg.lim.hyst, s_reg.lim.crit,
                                    s_reg.lim.low, s_reg.lim.high};
                ADDR_TEMP: s_next.rdata[8:0] = s_reg.temp;
                ADDR_STAT1:
                begin
                    // Return then clear.
                    s_next.rdata[STAT_HIGH] = s_reg.stat.high;
                    s_next.rdata[STAT_LOW]  = s_reg.stat.low;
                    if (!(conv_done && !hold) || s_reg.mode != MODE_COMPARATOR)
                    begin
                        s_next.stat.high = s_next.stat.high & (conv_done & !hold);
                        s_next.stat.low  = s_next.stat.low & (conv_done & !hold);
                    end
                end
                ADDR_EXT1:
                begin
                    // Critical status and control live here.
                    s_next.rdata[EXT1_CRIT_STAT] = s_reg.stat.crit;
                    s_next.rdata[EXT1_CRIT_EN]   = s_reg.crit_en;
                    if (s_reg.mode != MODE_COMPARATOR)
                        s_next.stat.crit = s_next.stat.crit & (conv_done & !hold);
                end
                default: s_next.rresp = RESP_SLVERR;
            endcase
        end
        if (s_reg.rvalid && s_axi_rready)
            s_next.rvalid = 1'b0;

        // Interrupt line: masked, enabled, held clear.
        s_next.int_n = !(!hold && s_next.config_bits[CFG_INT_EN] &&
                         ((s_next.stat.high && !s_next.int_mask[STAT_HIGH]) ||
                          (s_next.stat.low && !s_next.int_mask[STAT_LOW])));
        // Critical alert only in the extended option.
        s_next.crit_n = !(s_next.extended && s_next.crit_en && s_next.stat.crit);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // Latches clear, one-time normal by default.
            s_reg             <= '0;
            s_reg.config_bits <= CONFIG_RESET;
            s_reg.mode        <= MODE_ONE_TIME;
            s_reg.int_mask    <= MASK_RESET;
            s_reg.crit_en     <= EXT1_RESET[EXT1_CRIT_EN];
            s_reg.armed       <= '1;
            s_reg.int_n       <= 1'b1;
            s_reg.crit_n      <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign s_axi_awready    = !s_reg.aw_full;
    assign s_axi_wready     = !s_reg.w_full;
    assign s_axi_bvalid     = s_reg.bvalid;
    assign s_axi_bresp      = s_reg.bresp;
    assign s_axi_arready    = !s_reg.rvalid;
    assign s_axi_rvalid     = s_reg.rvalid;
    assign s_axi_rdata      = s_reg.rdata;
    assign s_axi_rresp      = s_reg.rresp;
    assign int_n            = s_reg.int_n;
    assign critical_alert_n = s_reg.crit_n;
    assign monitor_halt     = hold;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_hold_clears_line: assert property (@(posedge aclk) disable iff (!aresetn)
        hold |=> int_n)
        else $error("interrupt line active while hold bit set");

    a_normal_no_crit: assert property (@(posedge aclk) disable iff (!aresetn)
        !s_reg.extended && !$past(s_reg.extended) |-> critical_alert_n)
        else $error("critical alert active in normal option");

    a_hold_halts_loop: assert property (@(posedge aclk) disable iff (!aresetn)
        hold && conv_done |=> s_reg.temp == $past(s_reg.temp))
        else $error("temperature updated while halted");

    a_status_read_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        do_read && s_axi_araddr == ADDR_STAT1 && !conv_done
        |=> !s_reg.stat.high && !s_reg.stat.low)
        else $error("status not cleared by read");

    a_mask_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.int_mask == 2'h3 && $past(s_reg.int_mask) == 2'h3 |-> int_n)
        else $error("masked flag drove interrupt line");

    a_comp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && !hold && !s_reg.extended && s_reg.mode == MODE_COMPARATOR
        |=> s_reg.stat.high == $past(hot))
        else $error("comparator status does not follow high limit");

    a_ext_comp_crit: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && !hold && s_reg.extended && s_reg.mode == MODE_COMPARATOR
        && crit_hot |=> s_reg.stat.crit)
        else $error("critical status not set above limit");

    a_onetime_once: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && !hold && s_reg.mode == MODE_ONE_TIME && hot
        |=> !s_reg.armed.high)
        else $error("one-time high event not disarmed");

    a_bresp_pairs: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write response missing");

endmodule

// ==== design/temp_alarm_pkg.sv ====
/*
 * Constants and carrier types for the temperature alarm block.
 * Assumes a 100 MHz system clock and an AXI4-Lite register master.
 */
package temp_alarm_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_MODE   = 8'h04;
    localparam logic [7:0] ADDR_LIMITS = 8'h08;
    localparam logic [7:0] ADDR_TEMP   = 8'h0c;
    localparam logic [7:0] ADDR_STAT1  = 8'h10;
    localparam logic [7:0] ADDR_EXT1   = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_INT_EN     = 1;
    localparam int CFG_INT_HOLD   = 3;
    localparam int MODE_EXTENDED  = 2;
    localparam int STAT_HIGH      = 0;
    localparam int STAT_LOW       = 1;
    localparam int EXT1_CRIT_STAT = 0;
    localparam int EXT1_CRIT_EN   = 1;

    localparam logic [7:0] CONFIG_RESET = 8'h08;
    localparam logic [7:0] EXT1_RESET   = 8'h02;
    localparam logic [1:0] MASK_RESET   = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ONE_TIME,
        MODE_REPETITIVE,
        MODE_COMPARATOR
    } alarm_mode_t;

    typedef struct packed {
        logic signed [7:0] high;
        logic signed [7:0] low;
        logic signed [7:0] crit;
        logic [2:0]        hyst;
    } limits_t;

    typedef struct packed {
        logic high;
        logic low;
        logic crit;
    } flags_t;

    typedef struct packed {
        logic [7:0]  config_bits;
        logic [1:0]  int_mask;
        logic        extended;
        alarm_mode_t mode;
        logic        crit_en;
        limits_t     lim;
        logic signed [8:0] temp;
        flags_t      stat;
        flags_t      armed;
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        int_n;
        logic        crit_n;
    } state_t;

endpackage

// ==== test/conv_source.sv ====
/*
 * Converter model that feeds the alarm block one result per request.
 * Assumes the bench pulses go for one cycle with temp_in settled.
 */
`timescale 1ns/1ps
module conv_source
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       go,
    input  wire logic [8:0] temp_in,
    output logic            conv_done,
    output logic [8:0]      conv_temp
);
    // ------------------------------------------------------------------
    // Result is valid only with the strobe; otherwise it flips each cycle.
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        conv_done <= aresetn & go;
        conv_temp <= go ? temp_in : ~conv_temp;
    end
endmodule

// ==== test/test_temp_alarm_interrupt.sv ====
/*
 * Register-level bench for the temperature alarm block.
 * Assumes the converter model and the package in design/.
 */
`timescale 1ns/1ps
module test_temp_alarm_interrupt;
    import temp_alarm_pkg::*;
    logic        aclk = 0, aresetn = 0, go = 0;
    logic [8:0]  tv = 0, conv_temp;
    logic        conv_done, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, got;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, int_n, crit_n, halt;
    logic [1:0]  bresp, rresp, gresp, wr_exp;
    int          n_fail = 0, tests_run = 0;
    always #5 aclk = ~aclk;
    conv_source i_src (.aclk(aclk), .aresetn(aresetn), .go(go),
        .temp_in(tv), .conv_done(conv_done), .conv_temp(conv_temp));
    temp_alarm_interrupt i_dut (.aclk(aclk), .aresetn(aresetn),
        .conv_done(conv_done), .conv_temp(conv_temp),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .int_n(int_n),
        .critical_alert_n(crit_n), .monitor_halt(halt));
    // ------------------------------------------------------------------
    // Compare tasks and closing task.
    // ------------------------------------------------------------------
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: word %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic g, input logic e);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: pin %b, expected %b", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Bus and converter tasks, entered just after a rising edge.
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1;
        w = 1;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (aw || w)
        begin
            @(posedge aclk);
            if (aw && awready)
            begin
                aw = 0;
                awvalid <= 0;
            end
            if (w && wready)
            begin
                w = 0;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        gresp = bresp;
        bready <= 0;
        chk_word({30'h0, gresp}, {30'h0, wr_exp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        got = rdata;
        gresp = rresp;
        rready <= 0;
        chk_word(got, e);
        chk_word({30'h0, gresp}, {30'h0, er});
    endtask
    task automatic cv(input logic [7:0] d, input logic ei, input logic ec);
        go <= 1; tv <= {d, 1'b1};
        @(posedge aclk);
        go <= 0;
        repeat (3) @(posedge aclk);
        chk_pin(int_n, ei);
        chk_pin(crit_n, ec);
    endtask
    task automatic stat(input logic [31:0] e);
        rd(ADDR_STAT1, e, RESP_OKAY);
        @(posedge aclk);
        chk_pin(int_n, 1'b1);
    endtask
    // ------------------------------------------------------------------
    // Tests with high 40, low 10, critical 60, hysteresis 3.
    // ------------------------------------------------------------------
    initial
    begin
        wr_exp = RESP_OKAY;
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(ADDR_CONFIG, 32'h8, RESP_OKAY);
        rd(ADDR_EXT1, 32'h2, RESP_OKAY);
        rd(8'h20, 32'h0, RESP_SLVERR);
        chk_pin(halt, 1'b1);
        wr_exp = RESP_SLVERR;
        wr(8'h20, 32'h0);
        wr_exp = RESP_OKAY;
        wr(ADDR_CONFIG, 32'h2);
        chk_pin(halt, 1'b0);
        wr(ADDR_LIMITS, 32'h033c0a28);
        rd(ADDR_LIMITS, 32'h033c0a28, RESP_OKAY);
        $display("test setup done");
        cv(8'd41, 0, 1);
        rd(ADDR_TEMP, 32'h53, RESP_OKAY);
        stat(32'h1);
        cv(8'd41, 1, 1);
        stat(32'h0);
        cv(8'd37, 1, 1);
        cv(8'd41, 0, 1);
        stat(32'h1);
        $display("test normal one-time done");
        wr(ADDR_MODE, 32'h1);
        cv(8'd41, 0, 1);
        stat(32'h1);
        cv(8'd38, 0, 1);
        stat(32'h1);
        cv(8'd37, 1, 1);
        cv(8'd70, 0, 1);
        stat(32'h1);
        $display("test normal repetitive done");
        wr(ADDR_MODE, 32'h2);
        cv(8'd41, 0, 1);
        cv(8'd40, 1, 1);
        cv(8'd5, 1, 1);
        $display("test normal comparator done");
        wr(ADDR_MODE, 32'h5);
        cv(8'd70, 0, 0);
        rd(ADDR_EXT1, 32'h3, RESP_OKAY);
        @(posedge aclk);
        chk_pin(crit_n, 1'b1);
        stat(32'h1);
        cv(8'd58, 0, 0);
        rd(ADDR_EXT1, 32'h3, RESP_OKAY);
        stat(32'h1);
        cv(8'd37, 1, 1);
        cv(8'd10, 0, 1);
        stat(32'h2);
        cv(8'd13, 0, 1);
        stat(32'h2);
        cv(8'd14, 1, 1);
        $display("test extended repetitive done");
        wr(ADDR_MODE, 32'h6);
        cv(8'd10, 0, 1);
        cv(8'd13, 0, 1);
        cv(8'd14, 1, 1);
        cv(8'd41, 0, 1);
        cv(8'd38, 0, 1);
        cv(8'd37, 1, 1);
        cv(8'd70, 0, 0);
        cv(8'd57, 0, 1);
        cv(8'd37, 1, 1);
        $display("test extended comparator done");
        wr(ADDR_MODE, 32'h11);
        rd(ADDR_MODE, 32'h11, RESP_OKAY);
        cv(8'd41, 1, 1);
        stat(32'h1);
        wr(ADDR_MODE, 32'h1);
        wr(ADDR_CONFIG, 32'ha);
        chk_pin(halt, 1'b1);
        cv(8'd41, 1, 1);
        rd(ADDR_STAT1, 32'h0, RESP_OKAY);
        wr(ADDR_CONFIG, 32'h0);
        cv(8'd41, 1, 1);
        wr(ADDR_CONFIG, 32'h2);
        cv(8'd41, 0, 1);
        $display("test mask and hold done");
        wrap_up;
    end
    // ------------------------------------------------------------------
    // Watchdog: tests need about 230 cycles; the limit of 20000 cycles is far above that.
    // ------------------------------------------------------------------
    initial
    begin
        #200us;
        n_fail++;
        wrap_up;
    end
endmodule
